// >>> flash_cmd_device.sv
// device end: reset arm/execute and parameter header read
// Behaviour
// - completed reset restores standby and defaults
// - execute acts only right after arm
// - any other command cancels arm
// - opcodes taken single-wire or quad
// - single-wire mode ignores upper data lines
// - reset aborts program or erase
// - device busy for recovery after reset
// - read (single-wire mode only): opcode 5Ah plus three address bytes
// - one dummy byte, then bytes from address
// - chip select high ends read cleanly
// - signature, revision and header count bytes
// - first header: id, length, pointer
// - second header: vendor code, length, pointer
// - no-operation cancels arm only
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_device #(
  parameter logic [7:0] vendor_code = flash_cmd_pkg::vendor_code_default,
  parameter int recovery_cycles = flash_cmd_pkg::recovery_cycles
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // link
  flash_link_if.device link,
  // device state
  input  wire logic quad_cmd_mode,
  input  wire logic op_start,
  output logic      busy,
  output logic      op_active,
  output logic      op_aborted,
  output logic      reset_done
);
  typedef enum logic [1:0] {st_cmd, st_addr, st_dummy, st_data} phase_t;

  phase_t      phase_q;
  logic        sclk_q;
  logic [2:0]  bit_q;
  logic [7:0]  shift_q;
  logic [1:0]  byte_q;
  logic [23:0] addr_q;
  logic [7:0]  out_q;
  logic        armed_q;
  logic        busy_q;
  logic [15:0] busy_cnt_q;
  logic        op_q;
  logic [7:0]  op_cnt_q;
  logic        abort_q;
  logic        done_q;
  logic [3:0]  io_q;
  logic [3:0]  oe_n_q;

  wire        rise      = link.sclk & ~sclk_q;
  wire        fall      = ~link.sclk & sclk_q;
  wire        sel       = ~link.cs_n;
  wire [2:0]  bit_last  = quad_cmd_mode ? 3'd1 : 3'd7;
  // single-wire uses io0 only; quad packs four lines
  wire [7:0]  shifted   = quad_cmd_mode ?
                          {shift_q[3:0], link.io_host} :
                          {shift_q[6:0], link.io_host[0]};
  wire        byte_done = sel & rise & (bit_q == bit_last);
  wire        cmd_done  = byte_done & (phase_q == st_cmd) & ~busy_q;

  function automatic logic byte_is(input logic [7:0] b,
                                   input logic [7:0] op);
    return b == op;
  endfunction

  wire        is_arm    = byte_is(shifted, flash_cmd_pkg::reset_arm_cmd);
  wire        is_exec   = byte_is(shifted, flash_cmd_pkg::reset_exec_cmd);
  wire        is_read   = byte_is(shifted,
                                  flash_cmd_pkg::param_table_read_cmd);
  wire        do_reset  = cmd_done & is_exec & armed_q;
  wire [7:0]  rom_data;
  wire        first_bit = bit_q == 3'd0;
  wire [7:0]  out_byte  = first_bit ? rom_data : out_q;

  header_rom #(.vendor_code(vendor_code)) rom (
    .addr (addr_q),
    .data (rom_data)
  );

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= link.sclk;
    end
  end

  // command byte framing and read sequencing
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= st_cmd;
      bit_q   <= 3'd0;
      shift_q <= 8'h00;
      byte_q  <= 2'd0;
      addr_q  <= 24'h0;
    end else if (!sel || do_reset) begin
      phase_q <= st_cmd;
      bit_q   <= 3'd0;
      shift_q <= 8'h00;
      byte_q  <= 2'd0;
      addr_q  <= 24'h0;
    end else if (rise && phase_q != st_data) begin
      shift_q <= shifted;
      bit_q   <= (bit_q == bit_last) ? 3'd0 : bit_q + 3'd1;
      if (byte_done) begin
        unique case (phase_q)
          st_cmd: begin
            if (cmd_done && is_read && !quad_cmd_mode) begin
              phase_q <= st_addr;
            end
          end
          st_addr: begin
            addr_q <= {addr_q[15:0], shifted};
            if (byte_q == 2'(flash_cmd_pkg::addr_bytes - 1)) begin
              phase_q <= st_dummy;
              byte_q  <= 2'd0;
            end else begin
              byte_q <= byte_q + 2'd1;
            end
          end
          st_dummy: begin
            phase_q <= st_data;
          end
          st_data: phase_q <= phase_q;
        endcase
      end
    end else if (fall && phase_q == st_data && bit_q == 3'd7) begin
      addr_q <= addr_q + 24'd1;
      bit_q  <= 3'd0;
    end else if (fall && phase_q == st_data) begin
      bit_q <= bit_q + 3'd1;
    end
  end

  // serial output on io1, msb first, changed on falling edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_q  <= 8'h00;
      io_q   <= 4'h0;
      oe_n_q <= 4'hf;
    end else if (!sel || phase_q != st_data) begin
      oe_n_q <= 4'hf;
      io_q   <= 4'h0;
      out_q  <= rom_data;
    end else if (fall) begin
      oe_n_q <= 4'b1101;
      io_q   <= {2'b00, out_byte[7], 1'b0};
      out_q  <= {out_byte[6:0], 1'b0};
    end
  end

  // arm state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      armed_q <= 1'b0;
    end else if (cmd_done) begin
      armed_q <= is_arm;
    end
  end

  // program/erase model, reset and recovery
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      op_q       <= 1'b0;
      op_cnt_q   <= 8'h00;
      abort_q    <= 1'b0;
      busy_q     <= 1'b0;
      busy_cnt_q <= 16'h0;
      done_q     <= 1'b0;
    end else if (do_reset) begin
      abort_q    <= op_q;
      op_q       <= 1'b0;
      busy_q     <= 1'b1;
      busy_cnt_q <= op_q ? 16'(recovery_cycles * 2) :
                           16'(recovery_cycles);
      done_q     <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (busy_q) begin
        busy_cnt_q <= busy_cnt_q - 16'd1;
        if (busy_cnt_q == 16'd1) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end else if (op_start && !op_q) begin
        op_q     <= 1'b1;
        op_cnt_q <= 8'(flash_cmd_pkg::busy_op_cycles);
        abort_q  <= 1'b0;
      end else if (op_q) begin
        op_cnt_q <= op_cnt_q - 8'd1;
        if (op_cnt_q == 8'd1) begin
          op_q <= 1'b0;
        end
      end
    end
  end

  assign link.io_dev      = io_q;
  assign link.io_dev_oe_n = oe_n_q;
  assign busy             = busy_q;
  assign op_active        = op_q;
  assign op_aborted       = abort_q;
  assign reset_done       = done_q;
endmodule
`default_nettype wire

// >>> flash_cmd_pkg.sv
// package: opcodes, header table layout and timing for the flash command block
package flash_cmd_pkg;
  localparam logic [7:0] reset_arm_cmd        = 8'h66;
  localparam logic [7:0] reset_exec_cmd       = 8'h99;
  localparam logic [7:0] no_operation_cmd     = 8'h00;
  localparam logic [7:0] param_table_read_cmd = 8'h5a;
  localparam int         addr_bytes           = 3;
  localparam int         dummy_bytes          = 1;
  localparam int         header_bytes         = 24;
  localparam logic [7:0] unused_byte          = 8'hff;
  localparam logic [31:0] signature           = 32'h50444653;
  localparam logic [7:0] rev_minor            = 8'h00;
  localparam logic [7:0] rev_major            = 8'h01;
  localparam logic [7:0] header_count         = 8'h01;
  localparam logic [7:0] hdr0_id              = 8'h00;
  localparam logic [7:0] hdr0_len             = 8'h09;
  localparam logic [23:0] hdr0_ptr            = 24'h000030;
  localparam logic [7:0] hdr1_len             = 8'h04;
  localparam logic [23:0] hdr1_ptr            = 24'h000060;
  // arbitrary value, stands in for the vendor code
  localparam logic [7:0] vendor_code_default  = 8'h5e;
  localparam int         recovery_time_ns     = 40;
  localparam int         clock_mhz            = 200;
  localparam int         recovery_cycles      =
    (recovery_time_ns * clock_mhz + 999) / 1000;
  localparam int         busy_op_cycles       = 64;
endpackage

// >>> flash_link_if.sv
// interface: serial flash link between host controller and device
`timescale 1ns/1ps
`default_nettype none
interface flash_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] io_host;
  logic [3:0] io_host_oe_n;
  logic [3:0] io_dev;
  logic [3:0] io_dev_oe_n;
  modport host (output cs_n, output sclk, output io_host,
                output io_host_oe_n, input io_dev, input io_dev_oe_n);
  modport device (input cs_n, input sclk, input io_host,
                  input io_host_oe_n, output io_dev, output io_dev_oe_n);
endinterface
`default_nettype wire

// >>> header_rom.sv
// header table lookup: byte address to parameter header byte
`timescale 1ns/1ps
`default_nettype none
module header_rom #(
  parameter logic [7:0] vendor_code = flash_cmd_pkg::vendor_code_default
) (
  // lookup
  input  wire logic [23:0] addr,
  output logic      [7:0]  data
);
  always_comb begin
    data = flash_cmd_pkg::unused_byte;
    if (addr[23:5] == 19'h0) begin
      unique case (addr[4:0])
        5'h00: data = flash_cmd_pkg::signature[7:0];
        5'h01: data = flash_cmd_pkg::signature[15:8];
        5'h02: data = flash_cmd_pkg::signature[23:16];
        5'h03: data = flash_cmd_pkg::signature[31:24];
        5'h04: data = flash_cmd_pkg::rev_minor;
        5'h05: data = flash_cmd_pkg::rev_major;
        5'h06: data = flash_cmd_pkg::header_count;
        5'h08: data = flash_cmd_pkg::hdr0_id;
        5'h09: data = flash_cmd_pkg::rev_minor;
        5'h0a: data = flash_cmd_pkg::rev_major;
        5'h0b: data = flash_cmd_pkg::hdr0_len;
        5'h0c: data = flash_cmd_pkg::hdr0_ptr[7:0];
        5'h0d: data = flash_cmd_pkg::hdr0_ptr[15:8];
        5'h0e: data = flash_cmd_pkg::hdr0_ptr[23:16];
        5'h10: data = vendor_code;
        5'h11: data = flash_cmd_pkg::rev_minor;
        5'h12: data = flash_cmd_pkg::rev_major;
        5'h13: data = flash_cmd_pkg::hdr1_len;
        5'h14: data = flash_cmd_pkg::hdr1_ptr[7:0];
        5'h15: data = flash_cmd_pkg::hdr1_ptr[15:8];
        5'h16: data = flash_cmd_pkg::hdr1_ptr[23:16];
        default: data = flash_cmd_pkg::unused_byte;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> flash_cmd_host.sv
// host end: issues reset pair, no-op and parameter header reads
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_host (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // request
  input  wire logic        req,
  input  wire logic [7:0]  opcode,
  input  wire logic [23:0] addr,
  input  wire logic [7:0]  read_len,
  input  wire logic        quad_cmd_mode,
  output logic             ready,
  output logic             data_valid,
  output logic      [7:0]  data,
  // link
  flash_link_if.host link
);
  typedef enum logic [1:0] {st_idle, st_shift, st_read, st_gap} state_t;
  state_t      state_q;
  logic        sclk_q;
  logic        cs_n_q;
  logic [39:0] sh_q;
  logic [5:0]  bits_q;
  logic        quad_q;
  logic [7:0]  left_q;
  logic [2:0]  rbit_q;
  logic [7:0]  rx_q;
  logic        dv_q;
  logic [3:0]  io_q;

  wire is_read = opcode == flash_cmd_pkg::param_table_read_cmd;
  wire [5:0] tx_bits = is_read ? 6'd40 : 6'd8;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= st_idle;
      sclk_q  <= 1'b0;
      cs_n_q  <= 1'b1;
      sh_q    <= 40'h0;
      bits_q  <= 6'd0;
      quad_q  <= 1'b0;
      left_q  <= 8'h00;
      rbit_q  <= 3'd0;
      rx_q    <= 8'h00;
      dv_q    <= 1'b0;
      data    <= 8'h00;
      io_q    <= 4'h0;
    end else begin
      dv_q <= 1'b0;
      unique case (state_q)
        st_idle: begin
          if (req) begin
            cs_n_q  <= 1'b0;
            quad_q  <= quad_cmd_mode & ~is_read;
            sh_q    <= {opcode, addr, 8'h00};
            bits_q  <= (quad_cmd_mode & ~is_read) ? 6'd2 : tx_bits;
            left_q  <= is_read ? read_len : 8'h00;
            io_q    <= (quad_cmd_mode & ~is_read) ? opcode[7:4] :
                       {3'b000, opcode[7]};
            state_q <= st_shift;
          end
        end
        st_shift: begin
          sclk_q <= ~sclk_q;
          if (sclk_q) begin
            sh_q   <= quad_q ? {sh_q[35:0], 4'h0} : {sh_q[38:0], 1'b0};
            bits_q <= bits_q - 6'd1;
            io_q   <= quad_q ? sh_q[35:32] : {3'b000, sh_q[38]};
            if (bits_q == 6'd1) begin
              state_q <= (left_q != 8'h00) ? st_read : st_gap;
              rbit_q  <= 3'd0;
            end
          end
        end
        st_read: begin
          sclk_q <= ~sclk_q;
          // sample at sclk fall: device output lags its fall by a clock
          if (sclk_q) begin
            rx_q   <= {rx_q[6:0], link.io_dev[1]};
            rbit_q <= rbit_q + 3'd1;
            if (rbit_q == 3'd7) begin
              dv_q   <= 1'b1;
              data   <= {rx_q[6:0], link.io_dev[1]};
              left_q <= left_q - 8'd1;
              if (left_q == 8'd1) begin
                state_q <= st_gap;
              end
            end
          end
        end
        st_gap: begin
          sclk_q  <= 1'b0;
          cs_n_q  <= 1'b1;
          io_q    <= 4'h0;
          state_q <= st_idle;
        end
      endcase
    end
  end

  assign ready             = (state_q == st_idle);
  assign data_valid        = dv_q;
  assign link.cs_n         = cs_n_q;
  assign link.sclk         = sclk_q;
  assign link.io_host      = io_q;
  assign link.io_host_oe_n = quad_q ? 4'h0 : 4'b1110;
endmodule
`default_nettype wire

// >>> flash_link_checker.sv
// checker: link-level assertions on the serial flash interface
`timescale 1ns/1ps
`default_nettype none
module flash_link_checker (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // link
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic [3:0] io_host,
  input  wire logic [3:0] io_host_oe_n,
  input  wire logic [3:0] io_dev,
  input  wire logic [3:0] io_dev_oe_n
);
  logic [7:0] low_q;
  logic [7:0] low_d;
  // length of the current chip-select low frame
  assign low_d = cs_n ? 8'h00 : ((low_q == 8'hff) ? low_q : low_q + 8'h01);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) low_q <= 8'h00;
    else          low_q <= low_d;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence frame_end;
    $rose(cs_n);
  endsequence
  sequence dev_off;
    io_dev_oe_n == 4'hf;
  endsequence
  sequence idle_two;
    cs_n && $past(cs_n);
  endsequence
  sequence sclk_hi;
    !cs_n && !$past(cs_n) && sclk;
  endsequence
  sequence dev_starts;
    $fell(io_dev_oe_n[1]);
  endsequence
  AST_SCLK_IDLE: assert property (idle_two |-> !sclk)
    else $error("serial clock moved outside a frame");
  AST_DEV_IDLE_OFF: assert property (idle_two |-> dev_off)
    else $error("device drives link outside a frame");
  AST_DEV_RELEASE: assert property (frame_end |-> ##[0:1] dev_off)
    else $error("device late to release link");
  AST_DEV_SO_ONLY: assert property ((io_dev_oe_n | 4'b0010) == 4'hf)
    else $error("device drives a line other than serial out");
  AST_NO_CLASH: assert property (io_dev_oe_n[1] || io_host_oe_n[1])
    else $error("both ends drive serial out");
  AST_HOST_SETUP: assert property (sclk_hi |-> $stable(io_host[0]))
    else $error("host data changed while clock high");
  AST_MIN_FRAME: assert property (frame_end |-> low_q >= 8'd4)
    else $error("frame shorter than a quad opcode");
  AST_DUMMY_FIRST: assert property (dev_starts |-> low_q >= 8'd72)
    else $error("device output before address and dummy byte");
  AST_DEV_QUIET: assert property (io_dev_oe_n[1] |-> io_dev == 4'h0)
    else $error("device data not quiet while released");
endmodule
`default_nettype wire

// >>> testbench.sv
// testbench: both link ends joined, reset pair and header reads
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int         rc = 8;
  localparam logic [7:0] vc = 8'h3c; // arbitrary vendor code value
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        req = 1'b0;
  logic [7:0]  opcode = 8'h00;
  logic [23:0] addr = 24'h000000;
  logic [7:0]  read_len = 8'h00;
  logic        qmode = 1'b0;
  logic        op_start = 1'b0;
  logic        ready, data_valid, busy, op_active, op_aborted, reset_done;
  logic [7:0]  data;
  logic [7:0]  rx_q[$];
  logic [7:0]  exp_hdr[24];
  int          fail_count = 0;
  int          n_checks = 0;
  int          resets = 0;
  int          bcnt = 0;
  int          blen = 0;
  always #2.5 clock = ~clock;
  flash_link_if flash_link_if_inst ();
  flash_cmd_host flash_cmd_host_inst (.clock(clock), .reset_n(reset_n),
    .req(req), .opcode(opcode), .addr(addr), .read_len(read_len),
    .quad_cmd_mode(qmode), .ready(ready), .data_valid(data_valid),
    .data(data), .link(flash_link_if_inst.host));
  flash_cmd_device #(.vendor_code(vc), .recovery_cycles(rc))
    flash_cmd_device_inst (.clock(clock), .reset_n(reset_n),
    .link(flash_link_if_inst.device), .quad_cmd_mode(qmode),
    .op_start(op_start), .busy(busy), .op_active(op_active),
    .op_aborted(op_aborted), .reset_done(reset_done));
  flash_link_checker flash_link_checker_inst (.clock(clock),
    .reset_n(reset_n), .cs_n(flash_link_if_inst.cs_n),
    .sclk(flash_link_if_inst.sclk), .io_host(flash_link_if_inst.io_host),
    .io_host_oe_n(flash_link_if_inst.io_host_oe_n),
    .io_dev(flash_link_if_inst.io_dev),
    .io_dev_oe_n(flash_link_if_inst.io_dev_oe_n));
  // monitors: read bytes, reset pulses, busy length
  always @(negedge clock) begin
    if (data_valid === 1'b1) rx_q.push_back(data);
    if (reset_done === 1'b1) resets++;
    if (busy === 1'b1) bcnt++;
    else if (bcnt != 0) begin
      blen = bcnt;
      bcnt = 0;
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 2000 && (ready !== 1'b1 || busy !== 1'b0); i++)
      @(negedge clock);
    if (i == 2000) begin
      fail_count++;
      $display("MISMATCH %0t wait limit", $time);
      results();
    end
  endtask
  task automatic send(input logic [7:0] op, input logic [23:0] a,
                      input logic [7:0] n, input logic qm);
    wait_idle();
    opcode = op;
    addr = a;
    read_len = n;
    qmode = qm;
    req = 1'b1;
    @(negedge clock);
    req = 1'b0;
    repeat (2) @(negedge clock);
    wait_idle();
    repeat (3) @(negedge clock);
    wait_idle();
    repeat (2) @(negedge clock);
  endtask
  task automatic rd(input logic [23:0] a, input int n);
    int k;
    logic [7:0] e;
    rx_q.delete();
    send(flash_cmd_pkg::param_table_read_cmd, a, n[7:0], 1'b0);
    check(rx_q.size(), n, "read byte count");
    for (k = 0; k < rx_q.size(); k++) begin
      e = (a + k < 24) ? exp_hdr[a + k] : 8'hff;
      check(rx_q[k], e, "header byte");
    end
  endtask
  task automatic t_header();
    rd(24'h000000, 24);
    rd(24'h000010, 2);
    rd(24'h000016, 3);
    rd(24'h000005, 4);
    $display("test header done");
  endtask
  task automatic t_abort();
    int r;
    r = resets;
    op_start = 1'b1;
    @(negedge clock);
    op_start = 1'b0;
    @(negedge clock);
    check(op_active, 1'b1, "operation not started");
    send(flash_cmd_pkg::reset_arm_cmd, 24'h0, 8'h00, 1'b1);
    send(flash_cmd_pkg::reset_exec_cmd, 24'h0, 8'h00, 1'b1);
    check(resets, r + 1, "abort reset count");
    check(op_active, 1'b0, "operation not aborted");
    check(op_aborted, 1'b1, "abort flag");
    check(blen, 2 * rc, "recovery after abort");
    $display("test abort done");
  endtask
  task automatic t_reset();
    int r;
    for (int q = 0; q < 2; q++) begin
      r = resets;
      send(flash_cmd_pkg::reset_arm_cmd, 24'h0, 8'h00, q[0]);
      send(flash_cmd_pkg::reset_exec_cmd, 24'h0, 8'h00, q[0]);
      check(resets, r + 1, "reset pair count");
      check(blen, rc, "recovery length");
      check(op_aborted, 1'b0, "flag not cleared");
    end
    $display("test reset done");
  endtask
  task automatic t_cancel();
    int r;
    r = resets;
    send(flash_cmd_pkg::reset_arm_cmd, 24'h0, 8'h00, 1'b0);
    send(flash_cmd_pkg::no_operation_cmd, 24'h0, 8'h00, 1'b0);
    send(flash_cmd_pkg::reset_exec_cmd, 24'h0, 8'h00, 1'b0);
    check(resets, r, "no-op kept arm");
    send(flash_cmd_pkg::reset_arm_cmd, 24'h0, 8'h00, 1'b1);
    rd(24'h000000, 1);
    send(flash_cmd_pkg::reset_exec_cmd, 24'h0, 8'h00, 1'b1);
    check(resets, r, "read kept arm");
    send(flash_cmd_pkg::reset_exec_cmd, 24'h0, 8'h00, 1'b0);
    check(resets, r, "execute without arm");
    $display("test cancel done");
  endtask
  initial begin
    exp_hdr = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hff,
                8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff,
                vc, 8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hff};
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    t_header();
    t_abort();
    t_reset();
    t_cancel();
    results();
  end
endmodule
`default_nettype wire
